/* design/pwm_steer.sv */
// Enhanced PWM output stage: bridge modes, dead band, steering and auto-shutdown.
//
// Notes on behaviour
// - The bridge mode field selects single 00, half 10, full forward 01, full reverse 11.
// - Half bridge drives A and B complementary, edges apart by 4 clocks times the delay count.
// - Forward holds A active, B and C inactive, modulates D; reverse modulates B, C active.
// - The period is 4 clocks times (period register plus one) times (prescale plus one).
// - The pulse width is one clock times the ten-bit duty value times (prescale plus one).
// - Single mode drives the waveform only onto pins whose steering enable is set.
// - Steering applies only when ccp mode bits 3:2 are 11 and the bridge mode is 00.
// - With steering sync clear, steering changes take effect on the next clock.
// - A triggered enabled source sets the shutdown flag, which holds outputs in shutdown while ccp mode bits 3:2 are 11.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_steer_defines.svh"
module pwm_steer
    import pwm_steer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  shutdown_src,
    input  wire logic [3:0]  port_out,
    input  wire logic [3:0]  port_oe,
    output logic      [3:0]  pwm_out,
    output logic      [3:0]  pwm_oe,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  shutdown_ctrl_r;
    logic [4:0]  steer_ctrl_r;
    logic [3:0]  steer_act_r;
    logic [7:0]  ccp_ctrl_r;
    logic [7:0]  period_r;
    logic [7:0]  duty_high_r;
    logic [6:0]  deadband_r;
    logic [3:0]  prescale_r;
    logic [1:0]  irq_status_r;
    logic [1:0]  irq_mask_r;
    logic [2:0]  src_s1_r, src_s2_r, src_s3_r;
    logic [3:0]  pre_cnt_r;
    logic [9:0]  tick_cnt_r;
    logic        pwm_raw_r;
    logic        period_start;
    logic        wr_en;
    logic        sd_trig;
    logic        sd_clr;
    logic        db_a, db_b;
    logic [8:0]  db_cycles;
    logic [3:0]  pin_nxt;
    logic [3:0]  oe_nxt;
    logic        act_hi, act_lo;
    logic        mod_ac, mod_bd;
    bridge_mode_t mode;

    assign mode  = bridge_mode_t'(ccp_ctrl_r[`BIT_MODE_HI:`BIT_MODE_LO]);
    assign wr_en = psel && penable && pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file. Every access answers in the first access cycle; no wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `OFS_SHUTDOWN_CTRL: prdata <= {24'h000000, shutdown_ctrl_r};
                    `OFS_STEERING_CTRL: prdata <= {27'h0000000, steer_ctrl_r};
                    `OFS_CCP_CTRL:      prdata <= {24'h000000, ccp_ctrl_r};
                    `OFS_PERIOD:        prdata <= {24'h000000, period_r};
                    `OFS_DUTY_HIGH:     prdata <= {24'h000000, duty_high_r};
                    `OFS_DEADBAND:      prdata <= {25'h0000000, deadband_r};
                    `OFS_PRESCALE:      prdata <= {28'h0000000, prescale_r};
                    `OFS_IRQ_STATUS:    prdata <= {30'h00000000, irq_status_r};
                    `OFS_IRQ_MASK:      prdata <= {30'h00000000, irq_mask_r};
                    `OFS_PIN_STATE:     prdata <= {24'h000000, pwm_oe, pwm_out};
                    default:            pslverr <= 1'b1;
                endcase
            end else if (psel && !penable) begin
                unique case (paddr)
                    `OFS_SHUTDOWN_CTRL, `OFS_STEERING_CTRL, `OFS_CCP_CTRL, `OFS_PERIOD,
                    `OFS_DUTY_HIGH, `OFS_DEADBAND, `OFS_PRESCALE, `OFS_IRQ_STATUS,
                    `OFS_IRQ_MASK, `OFS_PIN_STATE: pslverr <= 1'b0;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Writes land on the access edge; pready is high there because the slave answers fast.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_ctrl_r <= `RST_STEERING_CTRL;
            ccp_ctrl_r   <= `RST_CCP_CTRL;
            period_r     <= `RST_PERIOD;
            duty_high_r  <= 8'h00;
            deadband_r   <= `RST_DEADBAND;
            prescale_r   <= `RST_PRESCALE;
            irq_mask_r   <= 2'b00;
        end else if (wr_en && pready) begin
            unique case (paddr)
                `OFS_STEERING_CTRL: steer_ctrl_r <= pwdata[4:0];
                `OFS_CCP_CTRL:      ccp_ctrl_r   <= pwdata[7:0];
                `OFS_PERIOD:        period_r     <= pwdata[7:0];
                `OFS_DUTY_HIGH:     duty_high_r  <= pwdata[7:0];
                `OFS_DEADBAND:      deadband_r   <= pwdata[6:0];
                `OFS_PRESCALE:      prescale_r   <= pwdata[3:0];
                `OFS_IRQ_MASK:      irq_mask_r   <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shutdown sources come from pins: three flops, a change counts once stages 2 and 3 agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s1_r <= 3'b000;
            src_s2_r <= 3'b000;
            src_s3_r <= 3'b000;
        end else begin
            src_s1_r <= shutdown_src;
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
        end
    end

    assign sd_trig = |(src_s2_r & src_s3_r & shutdown_ctrl_r[`BIT_SD_SRC_HI:`BIT_SD_SRC_LO]);
    assign sd_clr  = wr_en && pready && (paddr == `OFS_SHUTDOWN_CTRL) && !pwdata[`BIT_SD_EVENT];

    // The event flag is set by hardware and cleared by software writing a zero; set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_ctrl_r <= `RST_SHUTDOWN_CTRL;
        end else begin
            if (wr_en && pready && (paddr == `OFS_SHUTDOWN_CTRL)) begin
                shutdown_ctrl_r[`BIT_SD_SRC_HI:`BIT_SD_BD_LO] <=
                    pwdata[`BIT_SD_SRC_HI:`BIT_SD_BD_LO];
            end
            if (sd_clr) begin
                shutdown_ctrl_r[`BIT_SD_EVENT] <= 1'b0;
            end
            if (sd_trig) begin
                shutdown_ctrl_r[`BIT_SD_EVENT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase: prescale divides the clock; each count step is one clock at prescale 0.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r  <= 4'h0;
            tick_cnt_r <= 10'h000;
            pwm_raw_r  <= 1'b0;
        end else if (pre_cnt_r >= prescale_r) begin
            pre_cnt_r <= 4'h0;
            if (period_start) begin
                tick_cnt_r <= 10'h000;
            end else begin
                tick_cnt_r <= tick_cnt_r + 10'h001;
            end
            pwm_raw_r <= (period_start ? 10'h000 : tick_cnt_r + 10'h001)
                         < {duty_high_r, ccp_ctrl_r[`BIT_DUTY_LO_HI:`BIT_DUTY_LO_LO]};
        end else begin
            pre_cnt_r <= pre_cnt_r + 4'h1;
        end
    end

    // Period ends after 4 * (period + 1) steps.
    assign period_start = (pre_cnt_r >= prescale_r) &&
                          (tick_cnt_r == ({2'b00, period_r} + 10'h001) * 10'(`OSC_PER_CYCLE)
                                         - 10'h001);

    ////////////////////////////////////////////////////////////////////////////////
    // Steering takes effect at once or at the next period start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_act_r <= 4'(`RST_STEERING_CTRL);
        end else if (!steer_ctrl_r[`BIT_STEER_SYNC]) begin
            steer_act_r <= steer_ctrl_r[3:0];
        end else if (period_start) begin
            steer_act_r <= steer_ctrl_r[3:0];
        end
    end

    assign db_cycles = {deadband_r, 2'b00};

    deadband_delay #(.CW(9)) u_db_a (
        .pclk         (pclk),
        .presetn      (presetn),
        .din          (pwm_raw_r),
        .delay_cycles (db_cycles),
        .dout         (db_a)
    );

    deadband_delay #(.CW(9)) u_db_b (
        .pclk         (pclk),
        .presetn      (presetn),
        .din          (!pwm_raw_r),
        .delay_cycles (db_cycles),
        .dout         (db_b)
    );

    // Mode bits 1:0 give polarity: bit 1 inverts A/C, bit 0 inverts B/D.
    always_comb begin
        act_hi = 1'b1;
        act_lo = 1'b0;
        mod_ac = pwm_raw_r ^ ccp_ctrl_r[1];
        mod_bd = pwm_raw_r ^ ccp_ctrl_r[0];
        pin_nxt = port_out;
        oe_nxt  = port_oe;
        unique case (mode)
            MODE_SINGLE: begin
                if (ccp_ctrl_r[`BIT_CCPM_HI:2] == `PWM_MODE_BITS) begin
                    for (int i = 0; i < 4; i++) begin
                        if (steer_act_r[i]) begin
                            pin_nxt[i] = (i % 2 == 0) ? mod_ac : mod_bd;
                            oe_nxt[i]  = 1'b1;
                        end
                    end
                end
            end
            MODE_HALF: begin
                pin_nxt[1:0] = {db_b ^ ccp_ctrl_r[0], db_a ^ ccp_ctrl_r[1]};
                oe_nxt[1:0]  = 2'b11;
            end
            MODE_FULL_FWD: begin
                pin_nxt = {mod_bd, act_lo ^ ccp_ctrl_r[1], act_lo ^ ccp_ctrl_r[0],
                           act_hi ^ ccp_ctrl_r[1]};
                oe_nxt  = 4'hf;
            end
            MODE_FULL_REV: begin
                pin_nxt = {act_lo ^ ccp_ctrl_r[0], act_hi ^ ccp_ctrl_r[1], mod_bd,
                           act_lo ^ ccp_ctrl_r[1]};
                oe_nxt  = 4'hf;
            end
        endcase
        if (shutdown_ctrl_r[`BIT_SD_EVENT] && ccp_ctrl_r[`BIT_CCPM_HI:2] == `PWM_MODE_BITS) begin
            pin_nxt[0] = shutdown_ctrl_r[`BIT_SD_AC_LO];
            pin_nxt[2] = shutdown_ctrl_r[`BIT_SD_AC_LO];
            oe_nxt[0]  = !shutdown_ctrl_r[`BIT_SD_AC_HI];
            oe_nxt[2]  = !shutdown_ctrl_r[`BIT_SD_AC_HI];
            pin_nxt[1] = shutdown_ctrl_r[`BIT_SD_BD_LO];
            pin_nxt[3] = shutdown_ctrl_r[`BIT_SD_BD_LO];
            oe_nxt[1]  = !shutdown_ctrl_r[`BIT_SD_BD_HI];
            oe_nxt[3]  = !shutdown_ctrl_r[`BIT_SD_BD_HI];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 4'h0;
            pwm_oe  <= 4'h0;
        end else begin
            pwm_out <= pin_nxt;
            pwm_oe  <= oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: write one to clear, a new event in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= 2'b00;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_en && pready && paddr == `OFS_IRQ_STATUS && pwdata[i]) begin
                    irq_status_r[i] <= 1'b0;
                end
            end
            if (sd_trig) irq_status_r[`IRQ_SHUTDOWN] <= 1'b1;
            if (period_start) irq_status_r[`IRQ_PERIOD] <= 1'b1;
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    chk_sd_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        sd_trig |=> shutdown_ctrl_r[`BIT_SD_EVENT])
        else $error("shutdown flag not set after trigger");
    chk_sd_pins_ac: assert property (@(posedge pclk) disable iff (!presetn)
        (shutdown_ctrl_r[`BIT_SD_EVENT] && ccp_ctrl_r[3:2] == 2'b11
         && shutdown_ctrl_r[3:2] == 2'b00) |=> (pwm_out[0] == 1'b0 && pwm_oe[0]))
        else $error("A not driven low in shutdown");
    chk_half_ab_off: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_HALF && !shutdown_ctrl_r[7] && ccp_ctrl_r[1:0] == 2'b00)
        |=> !(pwm_out[0] && pwm_out[1]))
        else $error("half bridge outputs overlap");
    chk_fwd_a_act: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_FULL_FWD && !shutdown_ctrl_r[7] && ccp_ctrl_r[1:0] == 2'b00)
        |=> (pwm_out[0] && !pwm_out[1] && !pwm_out[2]))
        else $error("forward mode static pins wrong");
    chk_rev_c_act: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_FULL_REV && !shutdown_ctrl_r[7] && ccp_ctrl_r[1:0] == 2'b00)
        |=> (pwm_out[2] && !pwm_out[0] && !pwm_out[3]))
        else $error("reverse mode static pins wrong");
    chk_steer_off: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SINGLE && !shutdown_ctrl_r[7] && !steer_act_r[2])
        |=> (pwm_oe[2] == $past(port_oe[2])))
        else $error("unsteered pin not under port control");
    chk_steer_sync: assert property (@(posedge pclk) disable iff (!presetn)
        (steer_ctrl_r[4] && !period_start) |=> $stable(steer_act_r))
        else $error("synchronous steering changed mid period");
    chk_steer_now: assert property (@(posedge pclk) disable iff (!presetn)
        !steer_ctrl_r[4] |=> steer_act_r == $past(steer_ctrl_r[3:0]))
        else $error("steering not applied on next clock");
    // Shutdown levels of the B/D pair and release of the A/C pair.
    chk_sd_pins_bd: assert property (@(posedge pclk) disable iff (!presetn)
        (shutdown_ctrl_r[`BIT_SD_EVENT] && ccp_ctrl_r[`BIT_CCPM_HI:2] == `PWM_MODE_BITS
         && shutdown_ctrl_r[`BIT_SD_BD_HI:`BIT_SD_BD_LO] == 2'b01)
        |=> (pwm_out[1] && pwm_oe[1] && pwm_out[3] && pwm_oe[3]))
        else $error("B and D not driven high in shutdown");
    chk_sd_ac_float: assert property (@(posedge pclk) disable iff (!presetn)
        (shutdown_ctrl_r[`BIT_SD_EVENT] && ccp_ctrl_r[`BIT_CCPM_HI:2] == `PWM_MODE_BITS
         && shutdown_ctrl_r[`BIT_SD_AC_HI]) |=> (!pwm_oe[0] && !pwm_oe[2]))
        else $error("A and C not released in shutdown");
    chk_fwd_d_mod: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_FULL_FWD && !shutdown_ctrl_r[`BIT_SD_EVENT] && ccp_ctrl_r[1:0] == 2'b00)
        |=> (pwm_out[3] == $past(pwm_raw_r)))
        else $error("forward mode D not modulated");
    chk_half_cd_port: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_HALF && !shutdown_ctrl_r[`BIT_SD_EVENT])
        |=> (pwm_oe[3:2] == $past(port_oe[3:2]) && pwm_out[3:2] == $past(port_out[3:2])))
        else $error("half bridge took pins C or D");
    chk_steer_a_on: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SINGLE && !shutdown_ctrl_r[`BIT_SD_EVENT] && steer_act_r[0]
         && ccp_ctrl_r[`BIT_CCPM_HI:2] == `PWM_MODE_BITS)
        |=> (pwm_oe[0] && pwm_out[0] == ($past(pwm_raw_r) ^ $past(ccp_ctrl_r[1]))))
        else $error("steered pin A lacks the waveform");
endmodule
`default_nettype wire

/* design/pwm_steer_defines.svh */
// Register offsets, field positions, reset values and timing counts of the PWM output stage.
`ifndef PWM_STEER_DEFINES_SVH
`define PWM_STEER_DEFINES_SVH
`define OFS_SHUTDOWN_CTRL   12'h000
`define OFS_STEERING_CTRL   12'h004
`define OFS_CCP_CTRL        12'h008
`define OFS_PERIOD          12'h00c
`define OFS_DUTY_HIGH       12'h010
`define OFS_DEADBAND        12'h014
`define OFS_PRESCALE        12'h018
`define OFS_IRQ_STATUS      12'h01c
`define OFS_IRQ_MASK        12'h020
`define OFS_PIN_STATE       12'h024
`define RST_SHUTDOWN_CTRL   8'h00
`define RST_STEERING_CTRL   5'h01
`define RST_CCP_CTRL        8'h00
`define RST_PERIOD          8'hff
`define RST_DEADBAND        7'h00
`define RST_PRESCALE        4'h0
`define BIT_SD_EVENT        7
`define BIT_SD_SRC_HI       6
`define BIT_SD_SRC_LO       4
`define BIT_SD_AC_HI        3
`define BIT_SD_AC_LO        2
`define BIT_SD_BD_HI        1
`define BIT_SD_BD_LO        0
`define BIT_STEER_SYNC      4
`define BIT_MODE_HI         7
`define BIT_MODE_LO         6
`define BIT_DUTY_LO_HI      5
`define BIT_DUTY_LO_LO      4
`define BIT_CCPM_HI         3
`define BIT_CCPM_LO         0
`define IRQ_SHUTDOWN        0
`define IRQ_PERIOD          1
`define OSC_PER_CYCLE       3'd4
`define PWM_MODE_BITS       2'b11
`endif

/* design/pwm_steer_pkg.sv */
// Types shared by the PWM output stage.
package pwm_steer_pkg;
    typedef enum logic [1:0] {
        MODE_SINGLE   = 2'b00,
        MODE_FULL_FWD = 2'b01,
        MODE_HALF     = 2'b10,
        MODE_FULL_REV = 2'b11
    } bridge_mode_t;
endpackage

/* design/deadband_delay.sv */
// Rising-edge delay for one half-bridge output.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_steer_defines.svh"
module deadband_delay #(
    parameter int CW = 9
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          din,
    input  wire logic [CW-1:0] delay_cycles,
    output logic               dout
);
    logic [CW-1:0] cnt_r;

    // A rising input is held low for delay_cycles clocks; a falling input passes at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            dout  <= 1'b0;
        end else if (!din) begin
            cnt_r <= '0;
            dout  <= 1'b0;
        end else if (cnt_r >= delay_cycles) begin
            dout <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/bridge_model.sv */
// Behavioural power bridge driver: resolves pin levels and raises fault lines on command.
`timescale 1ns/1ns
`default_nettype none
module bridge_model (
    input  wire logic       pclk,
    input  wire logic [3:0] pwm_out,
    input  wire logic [3:0] pwm_oe,
    input  wire logic [2:0] trip,
    output logic      [3:0] pin_level,
    output logic      [2:0] fault
);
    logic [3:0] last_r = 4'h0;

    // Gate inputs have no pull, so a released pin shows a level that flips every cycle.
    always @(posedge pclk) begin
        last_r <= pin_level;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = pwm_oe[i] ? pwm_out[i] : ~last_r[i];
        end
    end

    assign fault = trip;
endmodule
`default_nettype wire

/* tb/pwm_steer_tb.sv */
// Self-checking bench for the PWM output stage over its register bus.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_steer_defines.svh"
module pwm_steer_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, plen;
    logic [3:0]  port_out, port_oe, pwm_out, pwm_oe, pin_level;
    logic [2:0]  trip, fault;
    logic [7:0]  cnt [4];
    int          error_cnt, n_tests, k;

    pwm_steer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shutdown_src(fault), .port_out(port_out), .port_oe(port_oe),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
    bridge_model u_bridge (.pclk(pclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .trip(trip),
        .pin_level(pin_level), .fault(fault));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Four whole periods of 16 clocks, so the phase at the start does not matter.
    // One period passes first, so that a new setting has reached the pins.
    task automatic wave(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                        input logic [7:0] d);
        repeat (16) @(posedge pclk);
        for (int i = 0; i < 4; i++) cnt[i] = 8'h00;
        repeat (64) begin
            @(posedge pclk);
            for (int i = 0; i < 4; i++) cnt[i] = cnt[i] + pin_level[i];
        end
        chk({cnt[3], cnt[2], cnt[1], cnt[0]}, {d, c, b, a});
    endtask

    task automatic per_len();
        time t0;
        @(posedge pin_level[0]);
        t0 = $time;
        @(posedge pin_level[0]);
        plen = 32'(($time - t0) / 10);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, trip} = '0;
        port_out = 4'b1010;
        port_oe = 4'hf;
        error_cnt = 0;
        n_tests = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`OFS_SHUTDOWN_CTRL, 32'h00);
        rd_chk(`OFS_STEERING_CTRL, 32'h01);
        rd_chk(`OFS_PERIOD, 32'hff);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        wr(`OFS_PERIOD, 32'h3);
        wr(`OFS_DUTY_HIGH, 32'h1);
        wr(`OFS_PRESCALE, 32'h0);
        wr(`OFS_CCP_CTRL, 32'h0c);
        wave(16, 64, 0, 64);
        wr(`OFS_STEERING_CTRL, 32'h0c);
        wave(0, 64, 16, 16);
        wr(`OFS_CCP_CTRL, 32'h0f);
        wave(0, 64, 48, 48);
        wr(`OFS_CCP_CTRL, 32'h08);
        wave(0, 64, 0, 64);
        wr(`OFS_CCP_CTRL, 32'h4c);
        wave(64, 0, 0, 16);
        wr(`OFS_CCP_CTRL, 32'hcc);
        wave(0, 16, 64, 0);
        wr(`OFS_DUTY_HIGH, 32'h2);
        wr(`OFS_CCP_CTRL, 32'h8c);
        wave(32, 32, 0, 64);
        wr(`OFS_DEADBAND, 32'h1);
        wave(16, 16, 0, 64);
        wr(`OFS_DEADBAND, 32'h0);
        wr(`OFS_DUTY_HIGH, 32'h1);
        wr(`OFS_CCP_CTRL, 32'h9c);
        wave(20, 44, 0, 64);
        wr(`OFS_PRESCALE, 32'h1);
        per_len();
        chk(plen, 32'd32);
        wr(`OFS_PRESCALE, 32'h0);
        wr(`OFS_CCP_CTRL, 32'h0c);
        // Catch a fresh period start, then change steering well past the pulse.
        wr(`OFS_IRQ_STATUS, 32'h3);
        k = 0;
        do begin
            apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
            k++;
        end while (rd[`IRQ_PERIOD] !== 1'b1 && k < 40);
        chk(rd[`IRQ_PERIOD], 1'b1);
        wr(`OFS_STEERING_CTRL, 32'h12);
        repeat (2) @(posedge pclk);
        chk({pwm_oe[1], pwm_out[1]}, 2'b11);
        wave(0, 16, 0, 64);
        wr(`OFS_STEERING_CTRL, 32'h0f);
        wr(`OFS_IRQ_STATUS, 32'h3);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_SHUTDOWN_CTRL, 32'h1d);
        trip <= 3'b010;
        repeat (10) @(posedge pclk);
        chk(irq, 1'b0);
        rd_chk(`OFS_SHUTDOWN_CTRL, 32'h1d);
        trip <= 3'b001;
        repeat (10) @(posedge pclk);
        rd_chk(`OFS_SHUTDOWN_CTRL, 32'h9d);
        chk({irq, pwm_oe, pwm_out[3], pwm_out[1]}, 7'b1101011);
        wr(`OFS_SHUTDOWN_CTRL, 32'h11);
        repeat (2) @(posedge pclk);
        chk({pwm_oe, pwm_out}, 8'hfa);
        rd_chk(`OFS_SHUTDOWN_CTRL, 32'h91);
        trip <= 3'b000;
        repeat (6) @(posedge pclk);
        wr(`OFS_SHUTDOWN_CTRL, 32'h11);
        rd_chk(`OFS_SHUTDOWN_CTRL, 32'h11);
        wave(16, 16, 16, 16);
        wr(`OFS_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
